// ==== hdl/scgrc_pkg.sv ====
// Overview of operation
// RULE1: Bits 6:5 select idle, noise, powerdown, standby.
// RULE2: Sleep entered only when sleep arm set.
// RULE3: Software arms just before, clears after wake.
// RULE4: Standby recommended only with crystal clock.
// RULE5: Control bits 7 and 3:2 read zero.
// RULE6: Gate register bits stop peripheral clocks.
// RULE7: Ungated timers and serials resume prior state.
// RULE8: Software reinitialises serial unit after ungating.
// RULE9: Software disables converter before gating it.
// RULE10: Comparator unavailable while converter gated.
// RULE11: Gate bit 7 reads zero; reset zero.
// RULE12: Reset forces registers; execution restarts at vector.
// RULE13: Ports reset immediately, no clock needed.
// RULE14: Delay counter stretches reset after sources clear.
// RULE15: Exactly four reset sources combined.
// RULE16: Power-on release counts; reassertion immediate.
// RULE17: Pin release starts full timeout count.
// RULE18: Pin ignored during power-on count unless low.
// RULE19: Watchdog pulse; count starts on falling edge.
// RULE20: Enabled brownout: low for detect time resets.
// RULE21: Sampled brownout: sample on 1kHz tick fall.
// RULE22: Sampled detection switches to enabled until release.
// RULE23: Two fuse pairs encode brownout mode.
// RULE24: Powerdown stops all clocks and oscillator.
// RULE25: Standby keeps oscillator; wake after six cycles.
// RULE26: Gated peripheral frozen, register access blocked.
// RULE27: One clock enable per peripheral, sleep combined.
package scgrc_pkg;
  localparam logic [7:0] ADDR_CLOCK_GATE  = 8'h34;
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'h38;
  localparam logic [7:0] ADDR_SLEEP_CMD   = 8'h3C;
  localparam logic [7:0] ADDR_STATUS      = 8'h40;
  localparam logic [7:0] CTRL_WR_MASK     = 8'h70;
  localparam logic [7:0] GATE_WR_MASK     = 8'h7F;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int         SLEEP_MODE_LO    = 5;
  localparam int         SLEEP_ARM_BIT    = 4;
  localparam int         GATE_CONVERTER   = 0;
  localparam int         NUM_PERIPH       = 7;
  localparam logic [1:0] SM_IDLE          = 2'h0;
  localparam logic [1:0] SM_NOISE         = 2'h1;
  localparam logic [1:0] SM_POWERDOWN     = 2'h2;
  localparam logic [1:0] SM_STANDBY       = 2'h3;
  localparam logic [1:0] BOD_RESERVED     = 2'h0;
  localparam logic [1:0] BOD_SAMPLED      = 2'h1;
  localparam logic [1:0] BOD_ENABLED      = 2'h2;
  localparam logic [1:0] BOD_DISABLED     = 2'h3;
  localparam int         CLK_MHZ          = 125;
  localparam int         TIMEOUT_US       = 64;
  localparam int         TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
  localparam int         BOD_DETECT_NS    = 2000;
  localparam int         BOD_DETECT_CYC   = (BOD_DETECT_NS + 7) / 8;
  localparam int         WAKE_CYCLES      = 6;
  localparam logic [1:0] AXI_OKAY         = 2'h0;
  localparam logic [1:0] AXI_SLVERR       = 2'h2;
endpackage : scgrc_pkg

// ==== hdl/scgrc_reg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface scgrc_reg_if;
  logic [7:0] gate;
  logic [1:0] mode;
  logic       arm;
  logic [1:0] bod_mode;
  logic       in_reset;
  logic       sleeping;
  modport regs (output gate, output mode, output arm, input bod_mode, input in_reset,
                input sleeping);
  modport core (input gate, input mode, input arm, output bod_mode, output in_reset,
                output sleeping);
endinterface : scgrc_reg_if
`default_nettype wire

// ==== hdl/scgrc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module scgrc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : scgrc_sync
`default_nettype wire

// ==== hdl/scgrc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module scgrc_top #(
  parameter int TIMEOUT_CYCLES = scgrc_pkg::TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // Reset sources.
  input  wire logic        por_ok_in,
  input  wire logic        ext_reset_n_in,
  input  wire logic        ext_reset_en_in,
  input  wire logic        wdt_expire_in,
  input  wire logic        wdt_en_in,
  input  wire logic        bod_low_in,
  input  wire logic        tick_1khz_in,
  input  wire logic [1:0]  brownout_active_fuses_in,
  input  wire logic [1:0]  brownout_sleep_fuses_in,
  // Sleep request and wake.
  input  wire logic        sleep_instr_in,
  input  wire logic        wake_in,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // System outputs.
  output logic             sys_reset_out,
  output logic             port_reset_out,
  output logic [6:0]       periph_clk_en_out,
  output logic             cpu_clk_en_out,
  output logic             osc_en_out,
  output logic             comparator_avail_out,
  output logic             bod_power_out
);

  ////////////////////////////////////////////////////////////////////////////
  scgrc_reg_if rif ();
  logic [4:0] src_raw;
  logic [4:0] src_s;
  assign src_raw = {tick_1khz_in, bod_low_in, wdt_expire_in, ext_reset_n_in, por_ok_in};
  scgrc_sync #(.W(5)) u_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (src_raw),
    .q_out     (src_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register slave; writes to the three writable addresses are answered OKAY but change no register while internal reset holds.
  logic [7:0] ctrl;
  logic [7:0] gate;
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic       w_strb0;
  logic       sleep_cmd;
  logic       do_write;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign do_write      = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 8'h00;
      w_strb0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_strb0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_hold <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scgrc_pkg::AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == scgrc_pkg::ADDR_CLOCK_GATE ||
                       aw_addr == scgrc_pkg::ADDR_POWER_CTRL ||
                       aw_addr == scgrc_pkg::ADDR_SLEEP_CMD) ?
                      scgrc_pkg::AXI_OKAY : scgrc_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Registers return to zero whenever the internal reset is held, not only at power-up.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl      <= scgrc_pkg::REG_RESET; // RULE12
      gate      <= scgrc_pkg::REG_RESET; // RULE11
      sleep_cmd <= 1'b0;
    end else if (sys_reset_out) begin
      ctrl      <= scgrc_pkg::REG_RESET; // RULE12
      gate      <= scgrc_pkg::REG_RESET;
      sleep_cmd <= 1'b0;
    end else begin
      sleep_cmd <= 1'b0;
      if (do_write && w_strb0) begin
        if (aw_addr == scgrc_pkg::ADDR_POWER_CTRL) begin
          ctrl <= w_data & scgrc_pkg::CTRL_WR_MASK; // RULE5
        end
        if (aw_addr == scgrc_pkg::ADDR_CLOCK_GATE) begin
          gate <= w_data & scgrc_pkg::GATE_WR_MASK; // RULE6 RULE11
        end
        if (aw_addr == scgrc_pkg::ADDR_SLEEP_CMD) begin
          sleep_cmd <= w_data[0];
        end
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= scgrc_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= scgrc_pkg::AXI_OKAY;
      unique case (s_axi_araddr)
        scgrc_pkg::ADDR_CLOCK_GATE: s_axi_rdata <= {24'h000000, gate};
        scgrc_pkg::ADDR_POWER_CTRL: s_axi_rdata <= {24'h000000, ctrl}; // RULE5
        scgrc_pkg::ADDR_SLEEP_CMD:  s_axi_rdata <= 32'h0000_0000;
        scgrc_pkg::ADDR_STATUS:
          s_axi_rdata <= {28'h0000000, rif.sleeping, rif.in_reset, rif.bod_mode};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= scgrc_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign rif.gate = gate;
  assign rif.mode = ctrl[scgrc_pkg::SLEEP_MODE_LO +: 2]; // RULE1
  assign rif.arm  = ctrl[scgrc_pkg::SLEEP_ARM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources: power-on, pin, watchdog, brown-out.
  logic ext_low;
  logic wdt_now;
  logic wdt_prev;
  logic wdt_fall;
  logic bod_reset;
  logic src_any;
  logic por_phase;
  logic [31:0] dly_cnt;
  assign ext_low  = ext_reset_en_in && !src_s[1];
  assign wdt_now  = wdt_en_in && src_s[2];
  assign wdt_fall = wdt_prev && !wdt_now; // RULE19
  // Pin is masked while the initial power-on count runs.
  assign src_any  = !src_s[0] || (ext_low && !por_phase) || wdt_now || bod_reset; // RULE15 RULE18
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdt_prev <= 1'b0;
    end else begin
      wdt_prev <= wdt_now;
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_cnt       <= 32'h0000_0000;
      sys_reset_out <= 1'b1;
      por_phase     <= 1'b1;
    end else if (src_any) begin
      dly_cnt       <= 32'h0000_0000; // RULE16
      sys_reset_out <= 1'b1;
      if (!src_s[0]) begin
        por_phase <= 1'b1;
      end
    end else if (sys_reset_out || wdt_fall) begin
      // Counting restarts from zero on a pin rise or watchdog fall.
      if (dly_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
        if (por_phase && ext_low) begin
          por_phase <= 1'b0; // RULE18
          dly_cnt   <= 32'h0000_0000;
        end else begin
          sys_reset_out <= 1'b0; // RULE14 RULE17
          por_phase     <= 1'b0;
        end
      end else begin
        dly_cnt <= dly_cnt + 32'h0000_0001;
      end
    end
  end
  // The raw power-on, pin and watchdog inputs bypass the synchroniser, as the ports must reset with no clock running; brown-out goes through it.
  assign port_reset_out = !arst_n_in || !por_ok_in || (ext_reset_en_in && !ext_reset_n_in) ||
                          (wdt_en_in && wdt_expire_in) || src_any ||
                          sys_reset_out; // RULE13
  assign rif.in_reset   = sys_reset_out;

  AST_DELAY_STRETCH: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE14
    $rose(src_any) |=> sys_reset_out [*8]) else $error("reset not stretched");
  AST_POR_IMMEDIATE: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE16
    !src_s[0] |-> port_reset_out ##1 sys_reset_out) else $error("por late");
  AST_REGS_CLEARED: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE12
    sys_reset_out |=> ctrl == 8'h00 && gate == 8'h00) else $error("regs kept");
  AST_RESERVED_ZERO: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE5
    ctrl[7] == 1'b0 && ctrl[3:2] == 2'h0 && gate[7] == 1'b0) else $error("reserved set");
  AST_WDT_COUNT: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE19
    wdt_fall && !src_any |=> sys_reset_out) else $error("watchdog count skipped");

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out mode from fuses, with sampled-to-enabled escalation.
  logic [1:0] fuse_mode;
  logic       escalated;
  logic       tick_prev;
  logic       tick_fall;
  logic       bod_sample_low;
  logic [15:0] bod_cnt;
  logic       deep_sleep;
  assign fuse_mode = deep_sleep ? brownout_sleep_fuses_in : brownout_active_fuses_in; // RULE23
  assign rif.bod_mode = escalated ? scgrc_pkg::BOD_ENABLED : fuse_mode; // RULE22
  assign tick_fall = tick_prev && !src_s[4];
  assign bod_power_out = rif.bod_mode == scgrc_pkg::BOD_ENABLED ||
                         (rif.bod_mode == scgrc_pkg::BOD_SAMPLED && tick_fall); // RULE21
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_prev      <= 1'b0;
      escalated      <= 1'b0;
      bod_sample_low <= 1'b0;
      bod_cnt        <= 16'h0000;
    end else begin
      tick_prev <= src_s[4];
      if (rif.bod_mode == scgrc_pkg::BOD_SAMPLED && tick_fall && src_s[3]) begin
        escalated <= 1'b1; // RULE22
      end else if (!sys_reset_out && !bod_reset) begin
        escalated <= 1'b0;
      end
      if (rif.bod_mode == scgrc_pkg::BOD_ENABLED && src_s[3]) begin
        if (bod_cnt < 16'(scgrc_pkg::BOD_DETECT_CYC)) begin
          bod_cnt <= bod_cnt + 16'h0001;
        end
      end else begin
        bod_cnt <= 16'h0000;
      end
      // Held until the supply is back above the trigger level.
      bod_sample_low <= (bod_cnt >= 16'(scgrc_pkg::BOD_DETECT_CYC - 1) && src_s[3]) ||
                        (bod_sample_low && src_s[3]); // RULE20
    end
  end
  // Escalation holds reset only while the supply is still low; otherwise reset could never release.
  assign bod_reset = bod_sample_low || (escalated && src_s[3]); // RULE22
  AST_BOD_HOLD: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE20
    bod_sample_low && src_s[3] |=> bod_sample_low) else $error("bod released early");
  AST_ESCALATE: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE22
    escalated |-> rif.bod_mode == scgrc_pkg::BOD_ENABLED) else $error("no escalation");
  AST_ESC_HOLD: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE22
    escalated && src_s[3] |=> sys_reset_out) else $error("escalated low not held");
  AST_SAMPLED_GAP: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE21
    rif.bod_mode == scgrc_pkg::BOD_SAMPLED && !tick_fall |-> !bod_power_out)
    else $error("detector on between samples");

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer and clock enables.
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_SLEEP = 3'h2,
    ST_WAKE  = 3'h4
  } scgrc_state_t;
  scgrc_state_t state;
  logic [2:0]   wake_cnt;
  logic [1:0]   act_mode;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state    <= ST_RUN;
      wake_cnt <= 3'h0;
      act_mode <= scgrc_pkg::SM_IDLE;
    end else if (sys_reset_out) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: if ((sleep_instr_in || sleep_cmd) && rif.arm) begin
          state    <= ST_SLEEP; // RULE2
          act_mode <= rif.mode;
        end
        ST_SLEEP: if (wake_in) begin
          state    <= ST_WAKE;
          wake_cnt <= 3'h0;
        end
        ST_WAKE: if (wake_cnt == 3'(scgrc_pkg::WAKE_CYCLES - 1)) begin
          state <= ST_RUN; // RULE25
        end else begin
          wake_cnt <= wake_cnt + 3'h1;
        end
      endcase
    end
  end
  assign rif.sleeping = state != ST_RUN;
  assign deep_sleep   = rif.sleeping && act_mode != scgrc_pkg::SM_IDLE;
  assign cpu_clk_en_out = !rif.sleeping && !sys_reset_out;
  assign osc_en_out = !(state == ST_SLEEP && act_mode == scgrc_pkg::SM_POWERDOWN); // RULE24
  // Gating only removes the enable; peripheral state is untouched, so it resumes.
  genvar gi;
  generate
    for (gi = 0; gi < scgrc_pkg::NUM_PERIPH; gi++) begin : g_en
      assign periph_clk_en_out[gi] = !rif.gate[gi] && !deep_sleep; // RULE6 RULE7 RULE26 RULE27
    end
  endgenerate
  assign comparator_avail_out = !rif.gate[scgrc_pkg::GATE_CONVERTER]; // RULE10
  AST_ARM_NEEDED: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE2
    state == ST_RUN && !rif.arm && !sys_reset_out |=> state == ST_RUN) else $error("slept unarmed");
  AST_WAKE_SIX: assert property (@(posedge mclk_in) // RULE25
    disable iff (!arst_n_in || sys_reset_out)
    state == ST_SLEEP && wake_in |=> !cpu_clk_en_out [*6] ##1 cpu_clk_en_out) else $error("wake time");
  AST_GATE_EN: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE10
    rif.gate[0] |-> !periph_clk_en_out[0] && !comparator_avail_out) else $error("gate leak");
  AST_PERIPH_SLEEP: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE27
    deep_sleep |-> periph_clk_en_out == '0) else $error("peripheral clock in deep sleep");
  AST_OSC_STOP: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE24
    state == ST_SLEEP && act_mode == scgrc_pkg::SM_POWERDOWN |->
    !osc_en_out && !cpu_clk_en_out) else $error("oscillator left running");
  AST_SLEEP_CAPTURE: assert property (@(posedge mclk_in) // RULE1 RULE2
    disable iff (!arst_n_in)
    state == ST_RUN && (sleep_instr_in || sleep_cmd) && rif.arm && !sys_reset_out |=>
    state == ST_SLEEP && act_mode == $past(rif.mode)) else $error("sleep entry wrong");
endmodule : scgrc_top
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int T = 20;
  logic        mclk_in, arst_n_in, por_ok_in, ext_reset_n_in, ext_reset_en_in;
  logic        wdt_expire_in, wdt_en_in, bod_low_in, tick_1khz_in, sleep_instr_in, wake_in;
  logic [1:0]  brownout_active_fuses_in, brownout_sleep_fuses_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        sys_reset_out, port_reset_out, cpu_clk_en_out, osc_en_out;
  logic        comparator_avail_out, bod_power_out;
  logic [6:0]  periph_clk_en_out;
  int          err_count, samples_checked, n;
  logic [1:0]  r;
  logic [31:0] d;
  typedef struct {
    logic [7:0] addr; logic [7:0] wr; logic [7:0] rd; logic [1:0] resp; logic [6:0] en; logic cmp;
  } scgrc_row_t;
  scgrc_row_t rows [6] = '{
    '{8'h34, 8'hFF, 8'h7F, 2'h0, 7'h00, 1'b0}, '{8'h38, 8'hFF, 8'h70, 2'h0, 7'h00, 1'b0},
    '{8'h34, 8'h2A, 8'h2A, 2'h0, 7'h55, 1'b1}, '{8'h38, 8'h8C, 8'h00, 2'h0, 7'h55, 1'b1},
    '{8'h50, 8'hFF, 8'h00, 2'h2, 7'h55, 1'b1}, '{8'h34, 8'h01, 8'h01, 2'h0, 7'h7E, 1'b0}};

  scgrc_top #(.TIMEOUT_CYCLES(T)) dut (.*);

  always #4 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task check_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_vec

  task check_bit(input logic got, input logic exp, input string what);
    check_vec({31'h0, got}, {31'h0, exp}, what);
  endtask : check_bit

  task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk_in);
      if (!aw_done && s_axi_awready === 1'b1) begin aw_done = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_done && s_axi_wready === 1'b1) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge mclk_in); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    // Response ready stays high between writes so back-to-back calls never drive it twice at once.
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk_in);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // Counts edges until the internal reset drops; the bound keeps a stuck reset from hanging.
  task wait_rel(input int lo, input int hi);
    n = 0;
    while (sys_reset_out !== 1'b0 && n < 2000) begin @(posedge mclk_in); n++; end
    check_bit(n >= lo && n <= hi, 1'b1, "reset stretch");
  endtask : wait_rel

  task do_reset;
    arst_n_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    wait_rel(T, T + 6);
  endtask : do_reset

  task hold(input int c);
    repeat (c) @(posedge mclk_in);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 30000);
    err_count++;
    wrap_up();
  end

  initial begin
    mclk_in = 1'b0; arst_n_in = 1'b0; por_ok_in = 1'b1; ext_reset_n_in = 1'b1;
    ext_reset_en_in = 1'b1; wdt_expire_in = 1'b0; wdt_en_in = 1'b1; bod_low_in = 1'b0;
    tick_1khz_in = 1'b1; sleep_instr_in = 1'b0; wake_in = 1'b0;
    brownout_active_fuses_in = 2'h3; brownout_sleep_fuses_in = 2'h3;
    s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; err_count = 0; samples_checked = 0;
    do_reset();
    for (int i = 0; i < 6; i++) begin
      axi_write(rows[i].addr, {24'h0, rows[i].wr}, r);
      check_vec(r, rows[i].resp, "bresp");
      axi_read(rows[i].addr, d, r);
      check_vec(d, {24'h0, rows[i].rd}, "rdata");
      check_vec(r, rows[i].resp, "rresp");
      check_vec(periph_clk_en_out, rows[i].en, "clock enables");
      check_bit(comparator_avail_out, rows[i].cmp, "comparator");
    end
    // Gate stays at 0x01 so idle can be told apart from the deeper modes.
    brownout_sleep_fuses_in <= 2'h2;
    for (int m = 0; m < 4; m++) begin
      axi_write(8'h38, {25'h0, m[1:0], 5'h10}, r);
      if (m == 3) axi_write(8'h3C, 32'h1, r);
      else begin sleep_instr_in <= 1'b1; @(posedge mclk_in); sleep_instr_in <= 1'b0; end
      hold(4);
      check_bit(cpu_clk_en_out, 1'b0, "cpu asleep");
      check_vec(periph_clk_en_out, (m == 0) ? 7'h7E : 7'h00, "sleep enables");
      check_bit(osc_en_out, m != 2, "oscillator");
      check_bit(bod_power_out, m != 0, "sleep detector");
      wake_in <= 1'b1; @(posedge mclk_in); wake_in <= 1'b0;
      n = 0;
      while (cpu_clk_en_out !== 1'b1 && n < 50) begin @(posedge mclk_in); n++; end
      if (m == 3) check_bit(n >= 6 && n <= 9, 1'b1, "wake time");
    end
    axi_write(8'h38, 32'h40, r);
    sleep_instr_in <= 1'b1; @(posedge mclk_in); sleep_instr_in <= 1'b0;
    hold(4);
    check_bit(cpu_clk_en_out, 1'b1, "unarmed sleep");
    ext_reset_n_in <= 1'b0; @(posedge mclk_in); #1;
    check_bit(port_reset_out, 1'b1, "port reset");
    hold(4);
    check_bit(sys_reset_out, 1'b1, "pin reset");
    ext_reset_n_in <= 1'b1;
    wait_rel(T, T + 6);
    axi_read(8'h34, d, r);
    check_vec(d, 32'h0, "gate cleared");
    ext_reset_en_in <= 1'b0; ext_reset_n_in <= 1'b0; hold(10);
    check_bit(sys_reset_out, 1'b0, "pin disabled");
    ext_reset_en_in <= 1'b1; ext_reset_n_in <= 1'b0; arst_n_in <= 1'b0; hold(5);
    arst_n_in <= 1'b1; hold(T + 12);
    check_bit(sys_reset_out, 1'b1, "pin low after count");
    ext_reset_n_in <= 1'b1;
    wait_rel(T, T + 6);
    por_ok_in <= 1'b0; @(posedge mclk_in); #1;
    check_bit(port_reset_out, 1'b1, "power drop");
    hold(4);
    check_bit(sys_reset_out, 1'b1, "power reset");
    por_ok_in <= 1'b1;
    wait_rel(T, T + 6);
    wdt_expire_in <= 1'b1; @(posedge mclk_in); wdt_expire_in <= 1'b0; hold(3);
    check_bit(sys_reset_out, 1'b1, "watchdog reset");
    wait_rel(T - 3, T + 8);
    wdt_en_in <= 1'b0; wdt_expire_in <= 1'b1; @(posedge mclk_in); wdt_expire_in <= 1'b0;
    hold(6);
    check_bit(sys_reset_out, 1'b0, "watchdog disabled");
    ////////////////////////////////////////////////////////////////////////////////
    brownout_active_fuses_in <= 2'h2; do_reset();
    check_bit(bod_power_out, 1'b1, "detector on");
    bod_low_in <= 1'b1; hold(100);
    check_bit(sys_reset_out, 1'b0, "short dip");
    hold(200);
    check_bit(sys_reset_out, 1'b1, "brownout reset");
    hold(50);
    check_bit(sys_reset_out, 1'b1, "held low");
    bod_low_in <= 1'b0;
    wait_rel(T, T + 8);
    brownout_active_fuses_in <= 2'h3; do_reset();
    bod_low_in <= 1'b1; hold(300);
    check_bit(sys_reset_out, 1'b0, "detector disabled");
    check_bit(bod_power_out, 1'b0, "detector off");
    bod_low_in <= 1'b0; brownout_active_fuses_in <= 2'h1; do_reset(); hold(5);
    check_bit(bod_power_out, 1'b0, "off between samples");
    bod_low_in <= 1'b1; tick_1khz_in <= 1'b0;
    n = 0;
    while (sys_reset_out !== 1'b1 && n < 600) begin @(posedge mclk_in); n++; end
    check_bit(sys_reset_out, 1'b1, "sampled brownout");
    check_bit(bod_power_out, 1'b1, "escalated");
    bod_low_in <= 1'b0;
    wait_rel(T, T + 8);
    hold(5);
    check_bit(bod_power_out, 1'b0, "back to sampled");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
